//--- hw/cmc_pkg.sv
// Constants for the CAN mode controller: register map, fields, states, timing.
// Assumes one 125 MHz clock and a byte-wide register port.
//
// Notes on behaviour
// - Module disabled stops every internal clock.
// - Sleep keeps only the register-access clock running.
// - Wake-up interrupt needs sleep request, sleep ack, wake enable, interrupt enable.
// - Wait with stop-in-wait powers down; leaving it returns to sleep if entered from sleep, else restarts into normal.
// - Wait without stop-in-wait keeps normal or sleep running.
// - Deep stop modes power down regardless of sleep bits.
// - Light stop sleeps if already asleep, else powers down; stop-in-wait ignored.
// - Sleep waits until every transmit buffer reads empty.
// - Sleep waits for bus idle when receiving, else enters after sync delay.
// - Sleep acknowledge set once sleep is active; host waits for it.
// - Sleep pauses bus-off recovery count; transmit pin stays recessive.
// - Sleep blocks moving new messages into the receive foreground buffer.
// - Sleep blocks transmit aborts; transmit buffers stay accessible.
// - Without wake enable latched at entry, receive input held recessive.
// - Sleep left by bus activity with wake enable, or request cleared after ack.
// - After wake-up wait eleven recessive bits before joining the bus.
// - On wake-up deferred copies, aborts, sends and bus-off counting resume.
// - Init mode aborts traffic at once and forces transmit pin recessive.
// - Init mode resets control state and unlocks configuration writes.
// - Init request passes two bus-side plus three core-side stages before ack.
// - Init request clearable only after acknowledge; host waits on acknowledge.
// - Power down stops traffic, forces recessive, blocks register access.

package cmc_pkg;
	// Register offsets
	localparam logic [3:0] CTRL_ADDR   = 4'h0;
	localparam logic [3:0] STATUS_ADDR = 4'h1;

	// Control register fields
	localparam int CTRL_INIT_REQ = 0;
	localparam int CTRL_SLP_REQ  = 1;
	localparam int CTRL_WAKE_EN  = 2;
	localparam int CTRL_STOP_WT  = 3;
	localparam int CTRL_WAKE_IE  = 4;
	localparam int CTRL_MOD_EN   = 7;

	// Status register fields
	localparam int STAT_INIT_ACK = 0;
	localparam int STAT_SLP_ACK  = 1;
	localparam int STAT_MODE_LSB = 4;

	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic       RECESSIVE  = 1'b1;

	// Timing
	localparam int CLK_MHZ        = 125;
	localparam int SLEEP_SYNC_NS  = 16;
	localparam int SLEEP_SYNC_CYC = (SLEEP_SYNC_NS * CLK_MHZ + 999) / 1000;
	localparam int RECOVER_NS     = 64;
	localparam int RECOVER_CYC    = (RECOVER_NS * CLK_MHZ + 999) / 1000;
	localparam int INIT_BUS_SYNC  = 2;
	localparam int INIT_CORE_SYNC = 3;
	localparam int INIT_SYNC_CYC  = INIT_BUS_SYNC + INIT_CORE_SYNC;
	localparam int RESYNC_BITS    = 11;

	// Controller modes
	typedef enum logic [2:0] {
		ST_DISABLED  = 3'b000,
		ST_NORMAL    = 3'b001,
		ST_SLEEP_PND = 3'b010,
		ST_SLEEP     = 3'b011,
		ST_RESYNC    = 3'b100,
		ST_POWERDOWN = 3'b101,
		ST_INIT      = 3'b110,
		ST_RECOVER   = 3'b111
	} cmc_state_t;
endpackage : cmc_pkg

//--- hw/cmc_mode_ctrl.sv
// Mode controller for a CAN protocol controller: enable, sleep, power down, init.
// Assumes the protocol engine supplies activity flags and a bit tick on clk.
// Logic reads only the second receive synchroniser stage; all outputs are registered.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module cmc_mode_ctrl (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_strobe,
	input  wire logic       rd_strobe,
	output logic      [7:0] rd_data,
	input  wire logic       cpu_wait,
	input  wire logic       cpu_stop3,
	input  wire logic       cpu_stop12,
	input  wire logic [2:0] tx_buffer_empty_flag,
	input  wire logic       tx_active,
	input  wire logic       rx_active,
	input  wire logic       bus_idle,
	input  wire logic       bus_off,
	input  wire logic       bit_tick,
	input  wire logic       engine_tx,
	input  wire logic       bus_receive_pin,
	output logic            bus_transmit_pin,
	output logic            engine_rx,
	output logic            core_clk_en,
	output logic            reg_clk_en,
	output logic            engine_halt,
	output logic            rx_shift_enable,
	output logic            abort_enable,
	output logic            boff_count_enable,
	output logic            cfg_write_enable,
	output logic            ctl_default_reset,
	output logic            wakeup_irq,
	output logic            sleep_acknowledge,
	output logic            init_acknowledge
);

	// Receive pin synchroniser
	logic rx_meta_reg;
	logic rx_sync_reg;

	// Two stages, both reset to the recessive idle level
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_meta_reg <= cmc_pkg::RECESSIVE;
			rx_sync_reg <= cmc_pkg::RECESSIVE;
		end else begin
			rx_meta_reg <= bus_receive_pin;
			rx_sync_reg <= rx_meta_reg;
		end
	end

	// Control bits and mode state
	cmc_pkg::cmc_state_t state_reg, state_next;
	logic       module_enable_reg, module_enable_next;
	logic       sleep_request_reg, sleep_request_next;
	logic       init_request_reg, init_request_next;
	logic       wakeup_enable_reg, wakeup_enable_next;
	logic       wakeup_interrupt_enable_reg, wakeup_interrupt_enable_next;
	logic       stop_in_wait_reg, stop_in_wait_next;
	logic       wake_latch_reg, wake_latch_next;
	logic       from_sleep_reg, from_sleep_next;
	logic [3:0] dly_reg, dly_next;
	logic [3:0] rec_bits_reg, rec_bits_next;

	// Combinational helpers
	logic       wake_pulse;
	logic       pd_cond;
	logic       tx_all_empty;
	logic       ctrl_wr;
	logic       init_ack_now;

	assign tx_all_empty = &tx_buffer_empty_flag;
	assign ctrl_wr      = wr_strobe && addr == cmc_pkg::CTRL_ADDR;
	assign init_ack_now = state_reg == cmc_pkg::ST_INIT
		&& dly_reg >= 4'(cmc_pkg::INIT_SYNC_CYC);

	// Power-down condition from the CPU mode
	always_comb begin
		pd_cond = 1'b0;
		if (cpu_stop12)
			pd_cond = 1'b1;
		else if (cpu_stop3)
			pd_cond = state_reg != cmc_pkg::ST_SLEEP;
		else if (cpu_wait)
			pd_cond = stop_in_wait_reg;
	end

	// Next control bits and mode
	always_comb begin
		state_next                   = state_reg;
		module_enable_next           = module_enable_reg;
		sleep_request_next           = sleep_request_reg;
		init_request_next            = init_request_reg;
		wakeup_enable_next           = wakeup_enable_reg;
		wakeup_interrupt_enable_next = wakeup_interrupt_enable_reg;
		stop_in_wait_next            = stop_in_wait_reg;
		wake_latch_next              = wake_latch_reg;
		from_sleep_next              = from_sleep_reg;
		dly_next                     = dly_reg;
		rec_bits_next                = rec_bits_reg;
		wake_pulse                   = 1'b0;

		// Software writes; none land while powered down
		if (ctrl_wr && state_reg != cmc_pkg::ST_POWERDOWN) begin
			if (wr_data[cmc_pkg::CTRL_MOD_EN])
				module_enable_next = 1'b1;
			if (wr_data[cmc_pkg::CTRL_SLP_REQ])
				sleep_request_next = 1'b1;
			else if (state_reg == cmc_pkg::ST_SLEEP)
				sleep_request_next = 1'b0;
			if (wr_data[cmc_pkg::CTRL_INIT_REQ])
				init_request_next = 1'b1;
			else if (init_ack_now)
				init_request_next = 1'b0;
			wakeup_enable_next           = wr_data[cmc_pkg::CTRL_WAKE_EN];
			wakeup_interrupt_enable_next = wr_data[cmc_pkg::CTRL_WAKE_IE];
			stop_in_wait_next            = wr_data[cmc_pkg::CTRL_STOP_WT];
		end

		// Count recessive bits for resync
		if (bit_tick) begin
			if (rx_sync_reg == cmc_pkg::RECESSIVE)
				rec_bits_next = rec_bits_reg + 4'h1;
			else
				rec_bits_next = 4'h0;
		end

		// Priority: disabled, power down, init, then the current mode
		if (!module_enable_reg) begin
			state_next = cmc_pkg::ST_DISABLED;
		end else if (pd_cond && state_reg != cmc_pkg::ST_POWERDOWN) begin
			state_next      = cmc_pkg::ST_POWERDOWN;
			from_sleep_next = state_reg == cmc_pkg::ST_SLEEP;
		end else if (init_request_reg && state_reg != cmc_pkg::ST_INIT
				&& state_reg != cmc_pkg::ST_POWERDOWN) begin
			state_next = cmc_pkg::ST_INIT;
			dly_next   = 4'h0;
		end else begin
			case (state_reg)
			// Enabled: resynchronise before joining the bus
			cmc_pkg::ST_DISABLED: begin
				state_next = cmc_pkg::ST_RESYNC;
				rec_bits_next = 4'h0;
			end

			// Sleep request starts the drain
			cmc_pkg::ST_NORMAL: begin
				if (sleep_request_reg) begin
					state_next = cmc_pkg::ST_SLEEP_PND;
					dly_next   = 4'h0;
				end
			end

			// Quiet engine, then the fixed sync delay
			cmc_pkg::ST_SLEEP_PND: begin
				// Drain transmit buffers and finish any reception first
				if (!tx_all_empty || tx_active || (rx_active && !bus_idle)) begin
					dly_next = 4'h0;
				end else if (dly_reg >= 4'(cmc_pkg::SLEEP_SYNC_CYC - 1)) begin
					state_next      = cmc_pkg::ST_SLEEP;
					wake_latch_next = wakeup_enable_reg;
				end else begin
					dly_next = dly_reg + 4'h1;
				end
			end

			// Leave on software clear or latched bus wake
			cmc_pkg::ST_SLEEP: begin
				if (!sleep_request_reg) begin
					state_next    = cmc_pkg::ST_RESYNC;
					rec_bits_next = 4'h0;
				end else if (wake_latch_reg && rx_sync_reg != cmc_pkg::RECESSIVE) begin
					state_next         = cmc_pkg::ST_RESYNC;
					sleep_request_next = 1'b0;
					rec_bits_next      = 4'h0;
					wake_pulse         = wakeup_interrupt_enable_reg;
				end
			end

			// Eleven recessive bit times before normal
			cmc_pkg::ST_RESYNC: begin
				if (rec_bits_reg >= 4'(cmc_pkg::RESYNC_BITS))
					state_next = cmc_pkg::ST_NORMAL;
			end

			// Back to sleep, or through the recovery cycle
			cmc_pkg::ST_POWERDOWN: begin
				if (!pd_cond) begin
					if (from_sleep_reg) begin
						state_next = cmc_pkg::ST_SLEEP;
					end else begin
						state_next = cmc_pkg::ST_RECOVER;
						dly_next   = 4'h0;
					end
				end
			end

			// Fixed recovery delay after power down
			cmc_pkg::ST_RECOVER: begin
				if (dly_reg >= 4'(cmc_pkg::RECOVER_CYC - 1)) begin
					state_next    = cmc_pkg::ST_RESYNC;
					rec_bits_next = 4'h0;
				end else begin
					dly_next = dly_reg + 4'h1;
				end
			end

			// Count sync stages; leave when the request drops
			cmc_pkg::ST_INIT: begin
				if (dly_reg < 4'(cmc_pkg::INIT_SYNC_CYC))
					dly_next = dly_reg + 4'h1;
				if (!init_request_reg) begin
					state_next    = cmc_pkg::ST_RESYNC;
					rec_bits_next = 4'h0;
				end
			end

			// Unused code falls back to disabled
			default: begin
				state_next = cmc_pkg::ST_DISABLED;
			end
			endcase
		end

		// Init mode holds the sleep, wake and stop-in-wait bits at defaults
		if (state_reg == cmc_pkg::ST_INIT) begin
			sleep_request_next           = 1'b0;
			wakeup_enable_next           = 1'b0;
			wakeup_interrupt_enable_next = 1'b0;
			stop_in_wait_next            = 1'b0;
		end
	end

	// Register control bits and mode
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg                   <= cmc_pkg::ST_DISABLED;
			module_enable_reg           <= cmc_pkg::CTRL_RESET[cmc_pkg::CTRL_MOD_EN];
			sleep_request_reg           <= cmc_pkg::CTRL_RESET[cmc_pkg::CTRL_SLP_REQ];
			init_request_reg            <= cmc_pkg::CTRL_RESET[cmc_pkg::CTRL_INIT_REQ];
			wakeup_enable_reg           <= cmc_pkg::CTRL_RESET[cmc_pkg::CTRL_WAKE_EN];
			wakeup_interrupt_enable_reg <= cmc_pkg::CTRL_RESET[cmc_pkg::CTRL_WAKE_IE];
			stop_in_wait_reg            <= cmc_pkg::CTRL_RESET[cmc_pkg::CTRL_STOP_WT];
			wake_latch_reg              <= 1'b0;
			from_sleep_reg              <= 1'b0;
			dly_reg                     <= 4'h0;
			rec_bits_reg                <= 4'h0;
		end else begin
			state_reg                   <= state_next;
			module_enable_reg           <= module_enable_next;
			sleep_request_reg           <= sleep_request_next;
			init_request_reg            <= init_request_next;
			wakeup_enable_reg           <= wakeup_enable_next;
			wakeup_interrupt_enable_reg <= wakeup_interrupt_enable_next;
			stop_in_wait_reg            <= stop_in_wait_next;
			wake_latch_reg              <= wake_latch_next;
			from_sleep_reg              <= from_sleep_next;
			dly_reg                     <= dly_next;
			rec_bits_reg                <= rec_bits_next;
		end
	end

	// Output next values; bus, clock and ack terms derived from the next mode
	logic       on_bus;
	logic       running;
	logic       slp_ack_n;
	logic       ini_ack_n;
	logic [7:0] rd_next;

	always_comb begin
		on_bus    = state_next == cmc_pkg::ST_NORMAL
			|| state_next == cmc_pkg::ST_SLEEP_PND;
		running   = on_bus || state_next == cmc_pkg::ST_RESYNC;
		slp_ack_n = state_next == cmc_pkg::ST_SLEEP && sleep_request_next;
		ini_ack_n = state_next == cmc_pkg::ST_INIT
			&& dly_next >= 4'(cmc_pkg::INIT_SYNC_CYC);

		// Read mux; zero when not reading or powered down
		rd_next   = 8'h00;
		if (rd_strobe && state_reg != cmc_pkg::ST_POWERDOWN) begin
			case (addr)
			cmc_pkg::CTRL_ADDR: begin
				rd_next[cmc_pkg::CTRL_MOD_EN]   = module_enable_reg;
				rd_next[cmc_pkg::CTRL_SLP_REQ]  = sleep_request_reg;
				rd_next[cmc_pkg::CTRL_INIT_REQ] = init_request_reg;
				rd_next[cmc_pkg::CTRL_WAKE_EN]  = wakeup_enable_reg;
				rd_next[cmc_pkg::CTRL_WAKE_IE]  = wakeup_interrupt_enable_reg;
				rd_next[cmc_pkg::CTRL_STOP_WT]  = stop_in_wait_reg;
			end
			cmc_pkg::STATUS_ADDR: begin
				rd_next[cmc_pkg::STAT_INIT_ACK] = init_acknowledge;
				rd_next[cmc_pkg::STAT_SLP_ACK]  = sleep_acknowledge;
				rd_next[cmc_pkg::STAT_MODE_LSB +: 3] = state_reg;
			end
			default: begin
				rd_next = 8'h00;
			end
			endcase
		end
	end

	// Registered outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data           <= 8'h00;
			bus_transmit_pin  <= cmc_pkg::RECESSIVE;
			engine_rx         <= cmc_pkg::RECESSIVE;
			core_clk_en       <= 1'b0;
			reg_clk_en        <= 1'b0;
			engine_halt       <= 1'b1;
			rx_shift_enable   <= 1'b0;
			abort_enable      <= 1'b0;
			boff_count_enable <= 1'b0;
			cfg_write_enable  <= 1'b0;
			ctl_default_reset <= 1'b0;
			wakeup_irq        <= 1'b0;
			sleep_acknowledge <= 1'b0;
			init_acknowledge  <= 1'b0;
		end else begin
			rd_data           <= rd_next;
			bus_transmit_pin  <= on_bus ? engine_tx : cmc_pkg::RECESSIVE;
			engine_rx         <= running ? rx_sync_reg : cmc_pkg::RECESSIVE;
			core_clk_en       <= running;
			reg_clk_en        <= module_enable_next
				&& state_next != cmc_pkg::ST_POWERDOWN;
			engine_halt       <= !on_bus;
			rx_shift_enable   <= running;
			abort_enable      <= running;
			boff_count_enable <= running && bus_off;
			cfg_write_enable  <= ini_ack_n;
			ctl_default_reset <= state_next == cmc_pkg::ST_INIT;
			wakeup_irq        <= wake_pulse;
			sleep_acknowledge <= slp_ack_n;
			init_acknowledge  <= ini_ack_n;
		end
	end

endmodule : cmc_mode_ctrl

`default_nettype wire

//--- verif/cmc_mode_ctrl_asserts.sv
// Checker for the CAN mode controller, bound to the controller's ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module cmc_mode_ctrl_asserts (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [2:0] tx_buffer_empty_flag,
	input wire logic       tx_active,
	input wire logic       rx_active,
	input wire logic       bus_idle,
	input wire logic       bus_transmit_pin,
	input wire logic       engine_rx,
	input wire logic       core_clk_en,
	input wire logic       reg_clk_en,
	input wire logic       engine_halt,
	input wire logic       rx_shift_enable,
	input wire logic       abort_enable,
	input wire logic       boff_count_enable,
	input wire logic       cfg_write_enable,
	input wire logic       ctl_default_reset,
	input wire logic       wakeup_irq,
	input wire logic       sleep_acknowledge,
	input wire logic       init_acknowledge
);
	logic idle_ok;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Engine quiet enough for sleep entry
	assign idle_ok = &tx_buffer_empty_flag && !tx_active && (!rx_active || bus_idle);
	core_gate_a: assert property (!reg_clk_en |-> !core_clk_en)
		else $error("core clock runs without register clock");
	sleep_gate_a: assert property (sleep_acknowledge |-> !core_clk_en && bus_transmit_pin && engine_rx)
		else $error("core active or bus driven while asleep");
	sleep_block_a: assert property (sleep_acknowledge |-> !rx_shift_enable && !abort_enable && !boff_count_enable)
		else $error("deferred action allowed while asleep");
	ack_cause_a: assert property ($rose(sleep_acknowledge) |-> $past(idle_ok))
		else $error("sleep acknowledged while engine busy");
	wake_irq_a: assert property (wakeup_irq |-> $past(sleep_acknowledge) && !sleep_acknowledge ##1 !wakeup_irq)
		else $error("wake pulse without leaving sleep");
	resync_a: assert property ($fell(sleep_acknowledge) |-> bus_transmit_pin [*8])
		else $error("bus driven right after wake");
	init_ack_a: assert property ($rose(ctl_default_reset) |-> !init_acknowledge [*4] ##[1:2] init_acknowledge)
		else $error("init acknowledge timing wrong");
	init_quiet_a: assert property (ctl_default_reset |-> engine_halt && bus_transmit_pin && !abort_enable)
		else $error("traffic not stopped in init");
	cfg_lock_a: assert property (cfg_write_enable |-> init_acknowledge && ctl_default_reset)
		else $error("configuration unlocked outside init");
endmodule : cmc_mode_ctrl_asserts
`default_nettype wire

//--- verif/cmc_bus_node.sv
// Far-side bus node: bit-time ticks and a dominant burst on demand.
// Assumes the bus line idles recessive through its pull-up.
`timescale 1ns/1ns
`default_nettype none
module cmc_bus_node (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic send_burst,
	output logic      bit_tick,
	output logic      bus_receive_pin
);
	logic [1:0] div_reg;
	logic [3:0] burst_reg;
	// Bit divider and a six-bit dominant frame start
	always_ff @(posedge clk) begin
		if (rst) begin
			div_reg   <= 2'h0;
			burst_reg <= 4'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
			if (send_burst)
				burst_reg <= 4'h6;
			else if (burst_reg != 4'h0 && div_reg == 2'h3)
				burst_reg <= burst_reg - 4'h1;
		end
	end
	assign bit_tick        = (div_reg == 2'h3);
	assign bus_receive_pin = (burst_reg == 4'h0);
endmodule : cmc_bus_node
`default_nettype wire

//--- verif/can_lowpower_init_mode_ctrl_test.sv
// Testbench for the CAN mode controller with a bus node model.
// Assumes a 125 MHz clock and register access over the plain strobe port.
`timescale 1ns/1ns
`default_nettype none
module can_lowpower_init_mode_ctrl_test;
	logic clk = 1'b0, rst = 1'b1, wr_strobe = 1'b0, rd_strobe = 1'b0, send_burst = 1'b0;
	logic cpu_wait = 1'b0, cpu_stop3 = 1'b0, cpu_stop12 = 1'b0, tx_active = 1'b0, rx_active = 1'b0;
	logic bus_idle = 1'b1, bus_off = 1'b0, engine_tx = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wr_data = 8'h00, irq_cnt = 8'h00;
	logic [2:0] tx_buffer_empty_flag = 3'h7;
	wire logic [7:0] rd_data;
	wire logic bit_tick, bus_receive_pin, bus_transmit_pin, engine_rx, core_clk_en, reg_clk_en, engine_halt;
	wire logic rx_shift_enable, abort_enable, boff_count_enable, cfg_write_enable, ctl_default_reset;
	wire logic wakeup_irq, sleep_acknowledge, init_acknowledge;
	int error_cnt = 0, n_tests = 0;

	cmc_mode_ctrl dut (.clk, .rst, .addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data, .cpu_wait, .cpu_stop3,
		.cpu_stop12, .tx_buffer_empty_flag, .tx_active, .rx_active, .bus_idle, .bus_off, .bit_tick, .engine_tx,
		.bus_receive_pin, .bus_transmit_pin, .engine_rx, .core_clk_en, .reg_clk_en, .engine_halt,
		.rx_shift_enable, .abort_enable, .boff_count_enable, .cfg_write_enable, .ctl_default_reset,
		.wakeup_irq, .sleep_acknowledge, .init_acknowledge);
	cmc_bus_node node (.clk, .rst, .send_burst, .bit_tick, .bus_receive_pin);

	always #4 clk = ~clk;
	// Count wake pulses
	always @(posedge clk) if (wakeup_irq === 1'b1) irq_cnt <= irq_cnt + 8'h01;

	function automatic logic [7:0] stat(cmc_pkg::cmc_state_t m, logic s);
		logic [7:0] v;
		v = 8'h00;
		v[cmc_pkg::STAT_MODE_LSB +: 3] = m;
		v[cmc_pkg::STAT_SLP_ACK]       = s;
		return v;
	endfunction : stat
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask : chk_bit
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr      <= a;
		wr_data   <= d;
		wr_strobe <= 1'b1;
		@(posedge clk);
		wr_strobe <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr      <= a;
		rd_strobe <= 1'b1;
		@(posedge clk);
		rd_strobe <= 1'b0;
		#1 d = rd_data;
	endtask : rd
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		chk_byte(v, exp);
	endtask : rd_chk
	task automatic wait_mode(input cmc_pkg::cmc_state_t m);
		logic [7:0] v;
		for (int i = 0; i < 100; i++) begin
			rd(cmc_pkg::STATUS_ADDR, v);
			if (v[6:4] === m)
				break;
		end
		chk_byte({5'h00, v[6:4]}, {5'h00, m});
	endtask : wait_mode

	// Watchdog well beyond the expected run
	initial begin
		#200000;
		error_cnt++;
		end_of_test();
	end

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// Reset values, unmapped place, disabled core clock
		rd_chk(cmc_pkg::CTRL_ADDR, cmc_pkg::CTRL_RESET);
		rd_chk(cmc_pkg::STATUS_ADDR, stat(cmc_pkg::ST_DISABLED, 1'b0));
		rd_chk(4'h9, 8'h00);
		chk_bit(core_clk_en, 1'b0);
		// Enable, resync, then the pin follows the engine
		wr(cmc_pkg::CTRL_ADDR, 8'h80);
		wait_mode(cmc_pkg::ST_NORMAL);
		@(posedge clk) engine_tx <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk_bit(bus_transmit_pin, 1'b0);
		@(posedge clk) engine_tx <= 1'b1;
		// Sleep held off by pending transmit and reception; flags settle first
		bus_off <= 1'b1;
		tx_buffer_empty_flag <= 3'b101;
		rx_active <= 1'b1;
		bus_idle <= 1'b0;
		wr(cmc_pkg::CTRL_ADDR, 8'h96);
		wr(cmc_pkg::CTRL_ADDR, 8'h94);
		rd_chk(cmc_pkg::CTRL_ADDR, 8'h96);
		chk_bit(boff_count_enable, 1'b1);
		repeat (10) @(posedge clk);
		chk_bit(sleep_acknowledge, 1'b0);
		@(posedge clk) tx_buffer_empty_flag <= 3'b111;
		repeat (10) @(posedge clk);
		chk_bit(sleep_acknowledge, 1'b0);
		@(posedge clk) bus_idle <= 1'b1;
		wait_mode(cmc_pkg::ST_SLEEP);
		chk_bit(sleep_acknowledge, 1'b1);
		chk_bit(reg_clk_en, 1'b1);
		chk_bit(boff_count_enable, 1'b0);
		// Bus activity wakes, frame lost to resync
		@(posedge clk) rx_active <= 1'b0;
		send_burst <= 1'b1;
		engine_tx <= 1'b0;
		@(posedge clk) send_burst <= 1'b0;
		wait_mode(cmc_pkg::ST_NORMAL);
		chk_byte(irq_cnt, 8'h01);
		rd_chk(cmc_pkg::CTRL_ADDR, 8'h94);
		chk_byte({5'h00, boff_count_enable, abort_enable, rx_shift_enable}, 8'h07);
		chk_bit(bus_transmit_pin, 1'b0);
		@(posedge clk) engine_tx <= 1'b1;
		// Without wake enable bus activity is masked
		wr(cmc_pkg::CTRL_ADDR, 8'h82);
		wait_mode(cmc_pkg::ST_SLEEP);
		@(posedge clk) send_burst <= 1'b1;
		@(posedge clk) send_burst <= 1'b0;
		repeat (40) @(posedge clk);
		rd_chk(cmc_pkg::STATUS_ADDR, stat(cmc_pkg::ST_SLEEP, 1'b1));
		chk_byte(irq_cnt, 8'h01);
		// Init from sleep; early clear of the request refused
		wr(cmc_pkg::CTRL_ADDR, 8'h83);
		wr(cmc_pkg::CTRL_ADDR, 8'h80);
		rd_chk(cmc_pkg::CTRL_ADDR, 8'h81);
		for (int i = 0; i < 20 && init_acknowledge !== 1'b1; i++) @(posedge clk);
		#1 chk_bit(cfg_write_enable, 1'b1);
		wr(cmc_pkg::CTRL_ADDR, 8'h80);
		wait_mode(cmc_pkg::ST_NORMAL);
		chk_bit(cfg_write_enable, 1'b0);
		// Wait without, then with, stop-in-wait
		@(posedge clk) cpu_wait <= 1'b1;
		rd_chk(cmc_pkg::STATUS_ADDR, stat(cmc_pkg::ST_NORMAL, 1'b0));
		@(posedge clk) cpu_wait <= 1'b0;
		wr(cmc_pkg::CTRL_ADDR, 8'h88);
		@(posedge clk) cpu_wait <= 1'b1;
		rd_chk(cmc_pkg::STATUS_ADDR, 8'h00);
		chk_bit(reg_clk_en, 1'b0);
		@(posedge clk) cpu_wait <= 1'b0;
		wait_mode(cmc_pkg::ST_NORMAL);
		// Stop modes when awake power down
		wr(cmc_pkg::CTRL_ADDR, 8'h80);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk) {cpu_stop3, cpu_stop12} <= (k == 0) ? 2'b10 : 2'b01;
			rd_chk(cmc_pkg::STATUS_ADDR, 8'h00);
			@(posedge clk) {cpu_stop3, cpu_stop12} <= 2'b00;
			wait_mode(cmc_pkg::ST_NORMAL);
		end
		// Light stop keeps sleep, deep stop powers down, exit back to sleep
		wr(cmc_pkg::CTRL_ADDR, 8'h82);
		wait_mode(cmc_pkg::ST_SLEEP);
		@(posedge clk) cpu_stop3 <= 1'b1;
		rd_chk(cmc_pkg::STATUS_ADDR, stat(cmc_pkg::ST_SLEEP, 1'b1));
		@(posedge clk) cpu_stop12 <= 1'b1;
		rd_chk(cmc_pkg::STATUS_ADDR, 8'h00);
		@(posedge clk) {cpu_stop3, cpu_stop12} <= 2'b00;
		wait_mode(cmc_pkg::ST_SLEEP);
		wr(cmc_pkg::CTRL_ADDR, 8'h80);
		wait_mode(cmc_pkg::ST_NORMAL);
		end_of_test();
	end
endmodule : can_lowpower_init_mode_ctrl_test

bind cmc_mode_ctrl cmc_mode_ctrl_asserts chk_i (.clk, .rst, .tx_buffer_empty_flag, .tx_active, .rx_active,
	.bus_idle, .bus_transmit_pin, .engine_rx, .core_clk_en, .reg_clk_en, .engine_halt, .rx_shift_enable,
	.abort_enable, .boff_count_enable, .cfg_write_enable, .ctl_default_reset, .wakeup_irq,
	.sleep_acknowledge, .init_acknowledge);
`default_nettype wire
